// *** fsp_pkg.sv ***
// Purpose: shared constants and types for the sector flash programming host
// Assumes: 40 MHz system clock, 16-bit flash data and address pins
// Notes:   times are kept in their printed units; cycle counts derive from them
package fsp_pkg;

  // ************************************************************
  // clock and timing
  // ************************************************************
  localparam int CLK_MHZ   = 40;
  localparam int T_WP_NS   = 200;  // write pulse width, least
  localparam int T_WPH_NS  = 200;  // write pulse width high, least
  localparam int T_ACC_NS  = 150;  // address/oe to output, read sample point
  localparam int T_OEHP_NS = 150;  // oe high pulse between polling reads
  localparam int T_WLC_US  = 150;  // word_load_gap_limit, longest
  localparam int T_WC_MS   = 20;   // program_cycle_duration, longest

  // least times round up, never below one cycle
  function automatic int min_cycles(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int WP_CYC   = min_cycles(T_WP_NS);
  localparam int WPH_CYC  = min_cycles(T_WPH_NS);
  localparam int ACC_CYC  = min_cycles(T_ACC_NS);
  localparam int OEHP_CYC = min_cycles(T_OEHP_NS);
  // longest times round down
  localparam int WLC_CYC  = T_WLC_US * CLK_MHZ;
  localparam int WC_CYC   = T_WC_MS * 1000 * CLK_MHZ;

  // ************************************************************
  // flash geometry and command sequences
  // ************************************************************
  localparam int          SECTOR_WORDS_DEF = 128;
  localparam int          SECTOR_LSB       = 7;
  localparam logic [15:0] SEQ_ADDR_A       = 16'h5555;
  localparam logic [15:0] SEQ_ADDR_B       = 16'h2aaa;
  localparam logic [7:0]  SEQ_DATA_A       = 8'haa;
  localparam logic [7:0]  SEQ_DATA_B       = 8'h55;
  localparam logic [7:0]  CMD_PROTECT      = 8'ha0;
  localparam logic [7:0]  CMD_ID_ENTER     = 8'h90;
  localparam logic [7:0]  CMD_ID_EXIT      = 8'hf0;
  localparam logic [1:0]  SEQ_LAST         = 2'h2;
  localparam int          TOG_LO_BIT       = 6;
  localparam int          TOG_HI_BIT       = 14;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [1:0] {FSP_OP_READ, FSP_OP_PROGRAM, FSP_OP_ID_ENTER, FSP_OP_ID_EXIT} fsp_op_type;

  typedef struct packed {
    fsp_op_type  op;
    logic [15:0] addr;   // read address, or any address inside the sector to program
  } fsp_req_type;

  typedef struct packed {
    logic [15:0] rdata;
    logic        timeout;
  } fsp_resp_type;

  typedef struct packed {
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic [15:0] addr;
    logic [15:0] dq_out;
    logic        dq_oe;
  } fsp_pins_type;

endpackage

// *** fsp_host.sv ***
// Purpose: host-side controller that reads, programs sectors and switches id mode on a parallel flash
// Assumes: flash pins are sampled and driven on clk; dq_in is synchronous to clk
// Notes:   a whole sector is staged in a local buffer so word loads run back to back
`timescale 1ns/1ps

module fsp_host
  import fsp_pkg::*;
#(
  parameter int SECTOR_WORDS = SECTOR_WORDS_DEF,
  parameter int WLC_CYCLES   = WLC_CYC,
  parameter int WC_CYCLES    = WC_CYC
)
(
  input  wire logic                            clk,
  input  wire logic                            nrst,
  input  wire logic                            clk_en,
  input  wire logic                            req_valid,
  input  wire fsp_req_type                     req,
  output logic                                 req_ready,
  output logic                                 resp_valid,
  output fsp_resp_type                         resp,
  input  wire logic                            buf_we,
  input  wire logic [$clog2(SECTOR_WORDS)-1:0] buf_idx,
  input  wire logic [15:0]                     buf_data,
  output fsp_pins_type                         pins,
  input  wire logic [15:0]                     dq_in,
  output logic                                 busy
);

  localparam int IW  = $clog2(SECTOR_WORDS);
  localparam int WCW = $clog2(WC_CYCLES + 1);
  localparam int CW  = 8;

  // ************************************************************
  // elaboration checks
  // ************************************************************
  if (SECTOR_WORDS != (1 << SECTOR_LSB))
    $error("sector size must match the sector address split");
  // one word load takes a write pulse plus a high pulse; it must fit the gap limit
  if (WP_CYC + WPH_CYC + 1 >= WLC_CYCLES)
    $error("word load period exceeds the load gap limit");
  if (WC_CYCLES < 1)
    $error("program cycle count must be positive");

  typedef enum logic [2:0] {ST_IDLE, ST_WR_LO, ST_WR_HI, ST_RD_LO, ST_RD_HI} fsp_state_type;
  typedef enum logic [1:0] {PH_CMD, PH_LOAD, PH_POLL, PH_SINGLE} fsp_phase_type;

  // ************************************************************
  // state
  // ************************************************************
  logic [15:0]   sector_buf [SECTOR_WORDS];
  fsp_state_type state,      next_state;
  fsp_phase_type phase,      next_phase;
  fsp_op_type    op;
  logic [1:0]    seq_idx,    next_seq_idx;
  logic [IW-1:0] word_idx,   next_word_idx;
  logic [CW-1:0] cnt,        next_cnt;
  logic [WCW-1:0] wc_cnt;
  logic          first_poll;
  logic          tog_stable;
  logic [1:0]    prev_tog;
  logic [15:0]   req_addr;
  logic          finish;
  logic          finish_timeout;

  // ************************************************************
  // decode
  // ************************************************************
  function automatic logic [7:0] seq_byte(input logic [1:0] idx, input fsp_op_type o);
    if (idx == 2'h0)
      return SEQ_DATA_A;
    else if (idx == 2'h1)
      return SEQ_DATA_B;
    else if (o == FSP_OP_PROGRAM)
      return CMD_PROTECT;
    else if (o == FSP_OP_ID_ENTER)
      return CMD_ID_ENTER;
    else
      return CMD_ID_EXIT;
  endfunction

  wire        cnt_done   = (cnt == '0);
  wire        start      = (state == ST_IDLE) && req_valid;
  wire [1:0]  tog_now    = {dq_in[TOG_HI_BIT], dq_in[TOG_LO_BIT]};
  wire        wc_expired = (wc_cnt >= WCW'(WC_CYCLES));
  wire [8:0]  sector     = req_addr[15:SECTOR_LSB];
  wire [15:0] poll_addr  = {sector, {SECTOR_LSB{1'b0}}};
  wire [15:0] seq_addr   = (next_seq_idx == 2'h1) ? SEQ_ADDR_B : SEQ_ADDR_A;
  wire [15:0] load_addr  = {sector, next_word_idx};
  // a single read leaves idle in the cycle req_addr is captured, so it takes the request's address directly
  wire [15:0] rd_addr    = (state == ST_IDLE) ? req.addr : req_addr;
  wire [15:0] next_addr  = (next_state == ST_RD_LO) ? ((next_phase == PH_POLL) ? poll_addr : rd_addr) :
                           (next_phase == PH_LOAD) ? load_addr : seq_addr;
  wire [15:0] next_dq    = (next_phase == PH_LOAD) ? sector_buf[next_word_idx] :
                           {8'h00, seq_byte(next_seq_idx, op)};
  wire        enter_lo   = (next_state == ST_WR_LO || next_state == ST_RD_LO) && (next_state != state);

  assign req_ready = (state == ST_IDLE);
  assign busy      = (state != ST_IDLE);

  // ************************************************************
  // sequencing
  // ************************************************************
  always_comb
  begin
    next_state     = state;
    next_phase     = phase;
    next_seq_idx   = seq_idx;
    next_word_idx  = word_idx;
    next_cnt       = cnt_done ? '0 : cnt - CW'(1);
    finish         = 1'b0;
    finish_timeout = 1'b0;
    case (state)
      ST_IDLE:
      begin
        if (req_valid)
        begin
          next_seq_idx  = '0;
          next_word_idx = '0;
          if (req.op == FSP_OP_READ)
          begin
            next_state = ST_RD_LO;
            next_phase = PH_SINGLE;
            next_cnt   = CW'(ACC_CYC - 1);
          end
          else
          begin
            // every program starts with a fresh unlock, since protection re-arms itself
            next_state = ST_WR_LO;
            next_phase = PH_CMD;
            next_cnt   = CW'(WP_CYC - 1);
          end
        end
      end
      ST_WR_LO:
      begin
        if (cnt_done)
        begin
          next_state = ST_WR_HI;
          next_cnt   = CW'(WPH_CYC - 1);
        end
      end
      ST_WR_HI:
      begin
        if (cnt_done)
        begin
          next_state = ST_WR_LO;
          next_cnt   = CW'(WP_CYC - 1);
          if (phase == PH_CMD && seq_idx != SEQ_LAST)
            next_seq_idx = seq_idx + 2'h1;
          else if (phase == PH_CMD && op == FSP_OP_PROGRAM)
            next_phase = PH_LOAD;
          else if (phase == PH_LOAD && word_idx != IW'(SECTOR_WORDS - 1))
            next_word_idx = word_idx + IW'(1);
          else if (phase == PH_LOAD)
          begin
            next_state = ST_RD_LO;
            next_phase = PH_POLL;
            next_cnt   = CW'(ACC_CYC - 1);
          end
          else
          begin
            next_state = ST_IDLE;
            finish     = 1'b1;
          end
        end
      end
      ST_RD_LO:
      begin
        if (cnt_done)
        begin
          next_state = ST_RD_HI;
          next_cnt   = CW'(OEHP_CYC - 1);
        end
      end
      ST_RD_HI:
      begin
        if (cnt_done)
        begin
          if (phase == PH_POLL && !tog_stable && !wc_expired)
          begin
            next_state = ST_RD_LO;
            next_cnt   = CW'(ACC_CYC - 1);
          end
          else
          begin
            next_state     = ST_IDLE;
            finish         = 1'b1;
            finish_timeout = (phase == PH_POLL) && !tog_stable;
          end
        end
      end
      default:
        next_state = ST_IDLE;
    endcase
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge clk)
  begin
    if (clk_en && buf_we)
      sector_buf[buf_idx] <= buf_data;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state    <= ST_IDLE;
      phase    <= PH_CMD;
      seq_idx  <= '0;
      word_idx <= '0;
      cnt      <= '0;
    end
    else if (clk_en)
    begin
      state    <= next_state;
      phase    <= next_phase;
      seq_idx  <= next_seq_idx;
      word_idx <= next_word_idx;
      cnt      <= next_cnt;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      op       <= FSP_OP_READ;
      req_addr <= '0;
    end
    else if (clk_en && start)
    begin
      op       <= req.op;
      req_addr <= req.addr;
    end
  end

  // polling bookkeeping; the first read has nothing to compare against
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      first_poll <= 1'b1;
      tog_stable <= 1'b0;
      prev_tog   <= '0;
      wc_cnt     <= '0;
    end
    else if (clk_en)
    begin
      if (phase != PH_POLL)
      begin
        first_poll <= 1'b1;
        tog_stable <= 1'b0;
        wc_cnt     <= '0;
      end
      else
      begin
        wc_cnt <= wc_expired ? wc_cnt : wc_cnt + WCW'(1);
        // compare two read samples; the bus between reads is not driven by the flash
        if (state == ST_RD_LO && cnt_done)
        begin
          prev_tog   <= tog_now;
          tog_stable <= !first_poll && (tog_now == prev_tog);
          first_poll <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      resp_valid <= 1'b0;
      resp       <= '0;
    end
    else if (clk_en)
    begin
      resp_valid <= finish;
      if (state == ST_RD_LO && cnt_done)
        resp.rdata <= dq_in;
      if (finish)
        resp.timeout <= finish_timeout;
    end
  end

  // pins follow the next state so strobes line up with state cycles
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      pins <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, dq_out: '0, dq_oe: 1'b0};
    else if (clk_en)
    begin
      pins.ce_n  <= !(next_state == ST_WR_LO || next_state == ST_RD_LO);
      pins.we_n  <= !(next_state == ST_WR_LO);
      pins.oe_n  <= !(next_state == ST_RD_LO);
      pins.dq_oe <= (next_state == ST_WR_LO || next_state == ST_WR_HI);
      if (enter_lo)
      begin
        pins.addr <= next_addr;
        if (next_state == ST_WR_LO)
          pins.dq_out <= next_dq;
      end
    end
  end

endmodule

// *** fsp_flash_model.sv ***
// Purpose: behavioural sector flash facing the host pins
// Assumes: pins registered on clk
// Notes:   released data bus flips every cycle
`timescale 1ns/1ps
module fsp_flash_model
  import fsp_pkg::*;
(
  input  wire fsp_pins_type pins,
  input  wire logic         clk,
  input  wire logic         nrst,
  output logic [15:0]       dq_in
);
  localparam logic [15:0] MAKER = 16'h00c3;  // arbitrary value
  localparam logic [15:0] PART  = 16'h00a7;  // arbitrary value
  logic [15:0] mem [0:65535];
  logic [15:0] lastd, q;
  logic [8:0]  sect;
  logic [7:0]  nload;
  logic [1:0]  seq;
  logic        loading, idm, tog, pw, po, bad;
  int          left;
  int          j;
  int          prog_len = 60;
  wire         wr = pw & !pins.we_n & !pins.ce_n;
  wire         rd = !pins.ce_n & !pins.oe_n & pins.we_n;
  wire [7:0]   d  = pins.dq_out[7:0];
  always_comb
    if (!rd)
      dq_in = ~q;
    else if (left > 0)
      dq_in = {~lastd[15], tog, 6'h00, ~lastd[7], tog, 6'h00};
    else if (idm && pins.addr[15:1] == 0)
      dq_in = pins.addr[0] ? PART : MAKER;
    else
      dq_in = mem[pins.addr];
  always @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      {seq, loading, idm, tog, bad, q, left} <= '0;
      pw <= 1'b1;
      po <= 1'b1;
    end
    else
    begin
      pw <= pins.we_n;
      po <= pins.oe_n;
      q  <= dq_in;
      if (left > 0)
        left <= left - 1;
      if (rd && po && left > 0)
        tog <= ~tog;
      if (wr && loading)
      begin
        if (nload == 0)
          for (j = 0; j < 128; j++)
            mem[{pins.addr[15:7], j[6:0]}] <= 'x;
        mem[pins.addr] <= pins.dq_out;
        lastd <= pins.dq_out;
        nload <= nload + 1;
        if (nload == 0)
          sect <= pins.addr[15:7];
        else if (pins.addr[15:7] != sect)
          bad <= 1'b1;
        if (nload == 127)
        begin
          loading <= 1'b0;
          left <= prog_len;
        end
      end
      else if (wr)
      begin
        seq <= (seq == 0 && pins.addr == SEQ_ADDR_A && d == SEQ_DATA_A) ? 2'h1 :
               (seq == 1 && pins.addr == SEQ_ADDR_B && d == SEQ_DATA_B) ? 2'h2 : 2'h0;
        if (seq == SEQ_LAST && pins.addr == SEQ_ADDR_A)
        begin
          loading <= (d == CMD_PROTECT);
          nload <= '0;
          if (d == CMD_ID_ENTER)
            idm <= 1'b1;
          if (d == CMD_ID_EXIT)
            idm <= 1'b0;
        end
      end
    end
endmodule

// *** fsp_host_chk.sv ***
// Purpose: pin timing and handshake checks for the flash host
// Assumes: sees only the host ports
// Notes:   one clock domain
`timescale 1ns/1ps
module fsp_host_chk
  import fsp_pkg::*;
(
  input wire logic         clk,
  input wire logic         nrst,
  input wire logic         clk_en,
  input wire logic         req_valid,
  input wire fsp_req_type  req,
  input wire logic         req_ready,
  input wire logic         resp_valid,
  input wire fsp_pins_type pins,
  input wire logic         busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire take_rd = clk_en && req_valid && req_ready && req.op == FSP_OP_READ;
  oe_write_a: assert property (!pins.we_n |-> pins.oe_n)
    else $error("output enable low during write");
  write_sel_a: assert property (!pins.we_n |-> !pins.ce_n && pins.dq_oe)
    else $error("write without select or data drive");
  write_len_a: assert property ($fell(pins.we_n) |-> (!pins.we_n)[*8] ##1 pins.we_n)
    else $error("write pulse length wrong");
  read_len_a: assert property ($fell(pins.oe_n) |-> (!pins.oe_n && !pins.ce_n && !pins.dq_oe)[*6] ##1 pins.oe_n)
    else $error("read pulse length wrong");
  resp_pulse_a: assert property (resp_valid |=> !resp_valid)
    else $error("response longer than one cycle");
  ready_busy_a: assert property (1'b1 |-> req_ready != busy)
    else $error("ready and busy disagree");
  read_walk_a: assert property (take_rd |=> pins.addr == $past(req.addr) ##12 resp_valid)
    else $error("read address or answer time wrong");
  idle_resp_a: assert property (resp_valid |-> !busy && pins.ce_n && pins.we_n)
    else $error("pins not released at answer");
endmodule
bind fsp_host fsp_host_chk u_chk (.clk(clk), .nrst(nrst), .clk_en(clk_en), .req_valid(req_valid), .req(req),
  .req_ready(req_ready), .resp_valid(resp_valid), .pins(pins), .busy(busy));

// *** fsp_host_tb.sv ***
// Purpose: self-checking bench for the flash sector host
// Assumes: flash model answers on the pins each cycle
// Notes:   program timeout shortened to 200 cycles
`timescale 1ns/1ps
module fsp_host_tb;
  import fsp_pkg::*;
  logic         clk, nrst, clk_en, req_valid, req_ready, resp_valid, busy, buf_we;
  fsp_req_type  req;
  fsp_resp_type resp;
  fsp_pins_type pins;
  logic [6:0]   buf_idx;
  logic [15:0]  buf_data, dq_in;
  int           err_count, num_checks, cyc;
  fsp_host #(.WC_CYCLES(200)) u_dut (.clk(clk), .nrst(nrst), .clk_en(clk_en), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .resp_valid(resp_valid), .resp(resp), .buf_we(buf_we), .buf_idx(buf_idx),
    .buf_data(buf_data), .pins(pins), .dq_in(dq_in), .busy(busy));
  fsp_flash_model u_flash (.clk(clk), .nrst(nrst), .pins(pins), .dq_in(dq_in));
  initial
  begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      summarize;
    end
  end
  // called at a falling edge with the host idle, so requests may follow back to back
  task automatic do_req(input fsp_op_type op, input logic [15:0] a);
    int n;
    req_valid = 1'b1;
    req = '{op, a};
    @(negedge clk);
    req_valid = 1'b0;
    for (n = 0; n < 4000 && resp_valid !== 1'b1; n++)
      @(negedge clk);
    check("resp_valid", resp_valid, 16'h0001);
  endtask
  task automatic t_read;
    u_flash.mem[16'h1234] = 16'hbeef;
    u_flash.mem[16'h1235] = 16'h0f0f;
    do_req(FSP_OP_READ, 16'h1234);
    check("read word", resp.rdata, 16'hbeef);
    do_req(FSP_OP_READ, 16'h1235);
    check("next read word", resp.rdata, 16'h0f0f);
    $display("read test done");
  endtask
  task automatic t_id;
    u_flash.mem[16'h0000] = 16'h1357;
    do_req(FSP_OP_ID_ENTER, 16'h0000);
    do_req(FSP_OP_READ, 16'h0000);
    check("maker id", resp.rdata, u_flash.MAKER);
    do_req(FSP_OP_READ, 16'h0001);
    check("part id", resp.rdata, u_flash.PART);
    do_req(FSP_OP_ID_EXIT, 16'h0000);
    do_req(FSP_OP_READ, 16'h0000);
    check("array after exit", resp.rdata, 16'h1357);
    $display("id test done");
  endtask
  // plen sets how long the model stays busy; longer than the timeout expects the flag
  task automatic t_prog(input logic [8:0] s, input int plen, input logic tmo);
    int i;
    for (i = 0; i < 128; i++)
    begin
      buf_we = 1'b1;
      buf_idx = i[6:0];
      buf_data = {s[7:0], i[7:0]} ^ 16'h5a00;
      @(negedge clk);
    end
    buf_we = 1'b0;
    u_flash.prog_len = plen;
    do_req(FSP_OP_PROGRAM, {s, 7'h05});
    check("timeout flag", resp.timeout, tmo);
    if (!tmo)
      check("poll word", resp.rdata, {s[7:0], 8'h00} ^ 16'h5a00);
    repeat (plen) @(negedge clk);
    for (i = 0; i < 128; i++)
      check("sector word", u_flash.mem[{s, i[6:0]}], {s[7:0], i[7:0]} ^ 16'h5a00);
    check("sector held", u_flash.bad, 16'h0000);
    do_req(FSP_OP_READ, {s, 7'h7f});
    check("read after program", resp.rdata, {s[7:0], 8'h7f} ^ 16'h5a00);
    $display("program test done");
  endtask
  initial
  begin
    {nrst, clk_en, req_valid, buf_we} = 4'h4;
    req = '0;
    buf_idx = '0;
    buf_data = '0;
    repeat (16) @(negedge clk);
    check("idle pins", {pins.ce_n, pins.oe_n, pins.we_n, pins.dq_oe, req_ready, busy}, 16'h003a);
    nrst = 1'b1;
    @(negedge clk);
    t_read;
    t_id;
    t_prog(9'h005, 60, 1'b0);
    t_prog(9'h1a3, 400, 1'b1);
    summarize;
  end
endmodule
